/* File: rtl/mbr_map.svh */
// constants, register map and rule summary for the modbus id router
// Summary of operation
// - a slave-port process and a master-port process run side by side with no shared state machine.
// - requests taken on the slave port can only reach the local register store.
// - the slave port answers at its own configurable address 1 to 246, separate from master-side ids.
// - on the master side id 1 is the radio, 199 local store, 200 i/o board and 201 display board.
// - ids 61 to 198 serve wired slaves or an extended wireless window.
// - the radio looks at every master request and forwards those inside its window, default 11 to 60.
// - the window start is a writable radio register at 6502, reset value 11.
// - the window size is a writable radio register at 6503 holding at most 100.
// - one engine serializes master transactions and an absent slave holds it for the whole timeout.
// - with no answer inside the timeout the transaction is marked lost and the next one starts.
// - the timeout runs from the end of the request to the answer, configurable, default 5 s; the engine reads timeoutCyc, TIMEOUT_CYC is unused.
// - below 1 s is advised when the radio is a star gateway.
// - bit 0 of display registers 1102 to 1105 at id 201 switches an indicator on or off.
`ifndef MBR_MAP_SVH
`define MBR_MAP_SVH
`define MBR_ID_RADIO 8'd1
`define MBR_ID_WIRED_LO 8'd2
`define MBR_ID_WIRED_HI 8'd10
`define MBR_ID_LOCAL 8'd199
`define MBR_ID_IOB 8'd200
`define MBR_ID_DISP 8'd201
`define MBR_ID_SLV_MAX 8'd246
`define MBR_REG_WIN_START 16'h1966
`define MBR_REG_WIN_SIZE 16'h1967
`define MBR_WIN_START_RST 16'h000b
`define MBR_WIN_SIZE_RST 16'h0032
`define MBR_WIN_SIZE_MAX 16'h0064
`define MBR_REG_LED_FIRST 16'h044e
`define MBR_LED_COUNT 4
`define MBR_SLV_ID_RST 8'd1
`define MBR_TIMEOUT_MS 5000
`define MBR_CLK_KHZ 200000
`define MBR_TIMEOUT_CYC (`MBR_TIMEOUT_MS * `MBR_CLK_KHZ)
`endif

/* File: rtl/mbr_pkg.sv */
// types shared by the modbus id router
package mbr_pkg;
  typedef enum logic [2:0] {
    MBR_DST_LOCAL,
    MBR_DST_IOB,
    MBR_DST_DISP,
    MBR_DST_RADIO,
    MBR_DST_WIRELESS,
    MBR_DST_WIRED
  } mbr_dst_t;

  typedef struct packed {
    logic [7:0] id;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } mbr_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic lost;
  } mbr_rsp_t;
endpackage

/* File: rtl/mbr_local_mem.sv */
// local register store with two ports and registered read data
module mbr_local_mem #(
  parameter int AW = 6
) (
  input wire logic clk_sys,
  input wire logic aWe,
  input wire logic [AW-1:0] aAddr,
  input wire logic [15:0] aWdata,
  output logic [15:0] aRdata,
  input wire logic bWe,
  input wire logic [AW-1:0] bAddr,
  input wire logic [15:0] bWdata,
  output logic [15:0] bRdata
);
  logic [15:0] mem [0:(1<<AW)-1];

  // port a wins on the same word because it is the master engine
  always_ff @(posedge clk_sys) begin
    if (bWe) begin
      mem[bAddr] <= bWdata;
    end
    if (aWe) begin
      mem[aAddr] <= aWdata;
    end
    aRdata <= mem[aAddr];
    bRdata <= mem[bAddr];
  end
endmodule // mbr_local_mem

/* File: rtl/mbr_router.sv */
// master engine, id router, radio window registers and slave port
`include "mbr_map.svh"
module mbr_router #(
  parameter int TIMEOUT_CYC = `MBR_TIMEOUT_CYC,
  parameter int MEM_AW = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] timeoutCyc,
  input wire logic mReqValid,
  output logic mReqReady,
  input wire mbr_pkg::mbr_req_t mReq,
  output logic mRspValid,
  output mbr_pkg::mbr_rsp_t mRsp,
  output logic extReqValid,
  output mbr_pkg::mbr_req_t extReq,
  output logic extWireless,
  input wire logic extSent,
  input wire logic extRspValid,
  input wire logic [15:0] extRspData,
  input wire logic [7:0] slvId,
  input wire logic sReqValid,
  input wire mbr_pkg::mbr_req_t sReq,
  output logic sRspValid,
  output mbr_pkg::mbr_rsp_t sRsp,
  output logic [`MBR_LED_COUNT-1:0] ledOn,
  output logic [15:0] winStart,
  output logic [15:0] winSize
);
  import mbr_pkg::*;

  // ****************************************
  // id decode
  // ****************************************
  function automatic mbr_dst_t route(input logic [7:0] id, input logic [15:0] st, input logic [15:0] sz);
    logic [16:0] idw;
    idw = {9'h000, id};
    if (id == `MBR_ID_LOCAL) begin
      route = MBR_DST_LOCAL;
    end else if (id == `MBR_ID_IOB) begin
      route = MBR_DST_IOB;
    end else if (id == `MBR_ID_DISP) begin
      route = MBR_DST_DISP;
    end else if (id == `MBR_ID_RADIO) begin
      route = MBR_DST_RADIO;
    end else if (idw >= {1'b0, st} && idw < ({1'b0, st} + {1'b0, sz})) begin
      route = MBR_DST_WIRELESS;
    end else begin
      route = MBR_DST_WIRED;
    end
  endfunction

  typedef enum logic [2:0] {ST_IDLE, ST_LOCAL, ST_SEND, ST_WAIT, ST_DONE} mbr_mst_t;

  mbr_mst_t st_q, st_d;
  mbr_req_t cur_q, cur_d;
  mbr_dst_t dst_q, dst_d;
  logic [31:0] tmr_q, tmr_d;
  mbr_rsp_t rsp_q, rsp_d;
  logic [15:0] winStart_q, winStart_d, winSize_q, winSize_d;
  logic [`MBR_LED_COUNT-1:0] led_q, led_d;
  logic [15:0] memA, memB;
  logic memAWe;
  logic sPend_q, sPend_d, sHit;
  logic [15:0] ledIdx;

  // ****************************************
  // master engine
  // ****************************************
  assign mReqReady = (st_q == ST_IDLE);
  assign ledIdx = cur_q.addr - `MBR_REG_LED_FIRST;
  assign memAWe = (st_q == ST_LOCAL) && cur_q.write;

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    dst_d = dst_q;
    tmr_d = tmr_q;
    rsp_d = rsp_q;
    winStart_d = winStart_q;
    winSize_d = winSize_q;
    led_d = led_q;
    case (st_q)
      ST_IDLE: begin
        if (mReqValid) begin
          cur_d = mReq;
          dst_d = route(mReq.id, winStart_q, winSize_q);
          st_d = (route(mReq.id, winStart_q, winSize_q) == MBR_DST_WIRED
                  || route(mReq.id, winStart_q, winSize_q) == MBR_DST_WIRELESS
                  || route(mReq.id, winStart_q, winSize_q) == MBR_DST_IOB) ? ST_SEND : ST_LOCAL;
        end
      end
      ST_LOCAL: begin
        rsp_d = '0;
        if (dst_q == MBR_DST_RADIO) begin
          if (cur_q.addr == `MBR_REG_WIN_START) begin
            if (cur_q.write) begin
              winStart_d = cur_q.data;
            end
            rsp_d.data = winStart_q;
          end else if (cur_q.addr == `MBR_REG_WIN_SIZE) begin
            // oversize writes clamp so the window never passes the limit
            if (cur_q.write) begin
              winSize_d = (cur_q.data > `MBR_WIN_SIZE_MAX) ? `MBR_WIN_SIZE_MAX : cur_q.data;
            end
            rsp_d.data = winSize_q;
          end
        end else if (dst_q == MBR_DST_DISP) begin
          if (ledIdx < `MBR_LED_COUNT) begin
            if (cur_q.write) begin
              led_d[ledIdx[1:0]] = cur_q.data[0];
            end
            rsp_d.data = {15'h0000, led_q[ledIdx[1:0]]};
          end
        end
        st_d = ST_DONE;
      end
      ST_SEND: begin
        tmr_d = '0;
        if (extSent) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (extRspValid) begin
          rsp_d = '{data: extRspData, lost: 1'b0};
          st_d = ST_DONE;
        end else if (tmr_q + 32'h0000_0001 >= timeoutCyc) begin
          rsp_d = '{data: 16'h0000, lost: 1'b1};
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      dst_q <= MBR_DST_LOCAL;
      tmr_q <= '0;
      rsp_q <= '0;
      winStart_q <= `MBR_WIN_START_RST;
      winSize_q <= `MBR_WIN_SIZE_RST;
      led_q <= '0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      dst_q <= dst_d;
      tmr_q <= tmr_d;
      rsp_q <= rsp_d;
      winStart_q <= winStart_d;
      winSize_q <= winSize_d;
      led_q <= led_d;
    end
  end

  // local store read data land a cycle after st_local
  assign mRspValid = (st_q == ST_DONE);
  assign mRsp = (dst_q == MBR_DST_LOCAL) ? mbr_rsp_t'{data: memA, lost: 1'b0} : rsp_q;
  assign extReqValid = (st_q == ST_SEND);
  assign extReq = cur_q;
  assign extWireless = (dst_q == MBR_DST_WIRELESS);
  assign ledOn = led_q;
  assign winStart = winStart_q;
  assign winSize = winSize_q;

  // ****************************************
  // slave port, runs alongside the engine
  // ****************************************
  // only the local store hangs off this port, nothing else is decoded
  assign sHit = sReqValid && (sReq.id == slvId) && (slvId != 8'd0) && (slvId <= `MBR_ID_SLV_MAX);

  always_comb begin
    sPend_d = sHit;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sPend_q <= 1'b0;
    end else begin
      sPend_q <= sPend_d;
    end
  end

  assign sRspValid = sPend_q;
  assign sRsp = '{data: memB, lost: 1'b0};

  mbr_local_mem #(.AW(MEM_AW)) mbr_local_mem_inst (
    .clk_sys(clk_sys),
    .aWe(memAWe && dst_q == MBR_DST_LOCAL),
    .aAddr(cur_q.addr[MEM_AW-1:0]),
    .aWdata(cur_q.data),
    .aRdata(memA),
    .bWe(sHit && sReq.write),
    .bAddr(sReq.addr[MEM_AW-1:0]),
    .bWdata(sReq.data),
    .bRdata(memB)
  );

  // ****************************************
  // checks
  // ****************************************
  a_timeout_lost: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == ST_WAIT && !extRspValid && tmr_q + 32'h0000_0001 >= timeoutCyc) |=> mRspValid && mRsp.lost)
    else $error("timeout did not mark lost");
  a_engine_busy: assert property (@(posedge clk_sys) disable iff (rst)
    (mReqValid && mReqReady) |=> !mReqReady)
    else $error("engine accepted while busy");
  a_window_cap: assert property (@(posedge clk_sys) disable iff (rst)
    winSize_q <= `MBR_WIN_SIZE_MAX)
    else $error("window size above limit");
  a_slave_answer: assert property (@(posedge clk_sys) disable iff (rst)
    sHit |=> sRspValid)
    else $error("slave port did not answer");
  a_slave_foreign: assert property (@(posedge clk_sys) disable iff (rst)
    (sReqValid && sReq.id != slvId) |=> !sRspValid)
    else $error("slave port answered foreign id");
  a_wireless_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (extReqValid && extWireless) |-> ({9'h000, extReq.id} >= {1'b0, winStart_q}
      && {9'h000, extReq.id} < {1'b0, winStart_q} + {1'b0, winSize_q}))
    else $error("wireless flag outside window");
  a_led_write: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == ST_LOCAL && dst_q == MBR_DST_DISP && cur_q.write && ledIdx == 16'h0000) |=> ledOn[0] == $past(cur_q.data[0]))
    else $error("indicator not updated");
  a_win_start: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == ST_LOCAL && dst_q == MBR_DST_RADIO && cur_q.write && cur_q.addr == `MBR_REG_WIN_START)
      |=> winStart == $past(cur_q.data))
    else $error("window start not written");
endmodule // mbr_router

/* File: testbench/mbr_ext_model.sv */
// far-side model of wired and forwarded slaves on the master bus
module mbr_ext_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic extReqValid,
  input wire mbr_pkg::mbr_req_t extReq,
  output logic extSent,
  output logic extRspValid,
  output logic [15:0] extRspData
);
  timeunit 1ns;
  timeprecision 100ps;
  import mbr_pkg::*;
  logic [7:0] id;
  logic [15:0] noise = 16'h5a5a;
  logic [15:0] ans;
  // ****
  // answers
  // ****
  // idle data keeps moving so a stale word never passes as an answer
  always @(posedge clk_sys) noise <= ~noise + 16'h0001;
  assign extRspData = extRspValid ? ans : noise;
  initial begin
    extSent = 0;
    extRspValid = 0;
    ans = 16'h0000;
    forever begin
      @(posedge clk_sys);
      if (extReqValid === 1'b1) begin
        id = extReq.id;
        repeat (slow ? 15 : 1) @(posedge clk_sys);
        #1 extSent = 1;
        @(posedge clk_sys);
        #1 extSent = 0;
        // absent ids stay silent, each present id answers once
        if ((id >= 8'd2 && id <= 8'd100) || id == 8'd200) begin
          repeat (slow ? 10 : 1) @(posedge clk_sys);
          #1 extRspValid = 1;
          ans = {8'ha5, id};
          @(posedge clk_sys);
          #1 extRspValid = 0;
        end
      end
    end
  end
endmodule // mbr_ext_model

/* File: testbench/test_mbr_router.sv */
// self-checking bench for the modbus id router
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_mbr_router;
  timeunit 1ns;
  timeprecision 100ps;
  import mbr_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic slow = 0;
  logic mReqValid = 0;
  logic sReqValid = 0;
  logic [7:0] slvId = 8'd246;
  logic [31:0] tmo = 32'h00000014;
  mbr_req_t mReq = '0;
  mbr_req_t sReq = '0;
  mbr_req_t extReq;
  mbr_rsp_t mRsp;
  mbr_rsp_t sRsp;
  mbr_rsp_t rsp;
  logic mReqReady, mRspValid, extReqValid, extWireless, extSent, extRspValid, sRspValid, wl, busy, got;
  logic [15:0] extRspData, winStart, winSize, q;
  logic [3:0] ledOn;
  int numErrors = 0;
  int samplesChecked = 0;
  int cyc;
  logic [7:0] ids [5] = '{8'd10, 8'd11, 8'd60, 8'd61, 8'd200};
  logic [4:0] wlTab = 5'h06;
  // ****
  // harness
  // ****
  initial forever #2.5 clk_sys = ~clk_sys;
  mbr_router #(.TIMEOUT_CYC(20)) mbr_router_inst (.clk_sys(clk_sys), .rst(rst), .timeoutCyc(tmo),
    .mReqValid(mReqValid), .mReqReady(mReqReady), .mReq(mReq), .mRspValid(mRspValid), .mRsp(mRsp),
    .extReqValid(extReqValid), .extReq(extReq), .extWireless(extWireless), .extSent(extSent),
    .extRspValid(extRspValid), .extRspData(extRspData), .slvId(slvId), .sReqValid(sReqValid), .sReq(sReq),
    .sRspValid(sRspValid), .sRsp(sRsp), .ledOn(ledOn), .winStart(winStart), .winSize(winSize));
  mbr_ext_model mbr_ext_model_inst (.clk_sys(clk_sys), .slow(slow), .extReqValid(extReqValid),
    .extReq(extReq), .extSent(extSent), .extRspValid(extRspValid), .extRspData(extRspData));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one master transaction, bounded wait on the answer pulse
  task automatic mTx(input logic [7:0] id, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 mReqValid = 1;
    mReq = '{id, wr, a, d};
    @(posedge clk_sys);
    #1 mReqValid = 0;
    cyc = 0;
    wl = 1'bx;
    busy = 0;
    got = 0;
    while (!got && cyc < 200) begin
      @(posedge clk_sys);
      cyc++;
      if (extReqValid === 1'b1) wl = extWireless;
      if (mReqReady === 1'b0) busy = 1;
      if (mRspValid === 1'b1) begin
        got = 1;
        rsp = mRsp;
      end
    end
    if (!got) begin
      numErrors++;
      $display("mismatch mRspValid expected 1 seen 0");
      conclude();
    end
  endtask
  task automatic sTx(input logic [7:0] id, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 sReqValid = 1;
    sReq = '{id, wr, a, d};
    @(posedge clk_sys);
    #1 sReqValid = 0;
    got = 0;
    q = 16'hxxxx;
    for (int i = 0; i < 3 && !got; i++) begin
      @(posedge clk_sys);
      if (sRspValid === 1'b1) begin
        got = 1;
        q = sRsp.data;
      end
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 0;
    `CHK("winStart", 16'h000b, winStart);
    `CHK("winSize", 16'h0032, winSize);
    `CHK("ledOn", 4'h0, ledOn);
    mTx(8'd1, 0, 16'h1966, 16'h0000);
    `CHK("startRd", 16'h000b, rsp.data);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      mTx(ids[i], 0, 16'h0000, 16'h0000);
      `CHK("wireless", wlTab[i], wl);
      `CHK("extData", {8'ha5, ids[i]}, rsp.data);
    end
    $display("test window done");
    mTx(8'd1, 1, 16'h1967, 16'h00ff);
    `CHK("sizeClamp", 16'h0064, winSize);
    mTx(8'd110, 0, 16'h0000, 16'h0000);
    `CHK("wideWin", 1'b1, wl);
    `CHK("lost", 1'b1, rsp.lost);
    `CHK("fullWait", 1'b1, cyc >= 20);
    `CHK("busy", 1'b1, busy);
    mTx(8'd111, 0, 16'h0000, 16'h0000);
    `CHK("winEnd", 1'b0, wl);
    mTx(8'd1, 1, 16'h1966, 16'h0005);
    `CHK("startWr", 16'h0005, winStart);
    mTx(8'd4, 0, 16'h0000, 16'h0000);
    `CHK("belowWin", 1'b0, wl);
    slow = 1;
    mTx(8'd5, 0, 16'h0000, 16'h0000);
    `CHK("atStart", 1'b1, wl);
    `CHK("slowOk", 1'b0, rsp.lost);
    `CHK("slowLong", 1'b1, cyc > 20);
    slow = 0;
    // a shorter limit must cut an absent slave sooner
    #1 tmo = 32'h00000008;
    mTx(8'd120, 0, 16'h0000, 16'h0000);
    `CHK("shortLost", 1'b1, rsp.lost);
    `CHK("shortTmo", 1'b1, cyc < 20);
    $display("test timeout done");
    for (int i = 0; i < 4; i++) begin
      mTx(8'd201, 1, 16'h044e + 16'(i), 16'h0001);
      `CHK("ledOn", 4'((1 << (i + 1)) - 1), ledOn);
    end
    mTx(8'd201, 1, 16'h044f, 16'h0002);
    `CHK("ledOff", 4'hd, ledOn);
    $display("test leds done");
    mTx(8'd199, 1, 16'h0005, 16'h1234);
    sTx(8'd246, 0, 16'h0005, 16'h0000);
    `CHK("slvRd", 16'h1234, q);
    sTx(8'd245, 0, 16'h0005, 16'h0000);
    `CHK("slvOther", 1'b0, got);
    sTx(8'd246, 1, 16'h0006, 16'hbeef);
    mTx(8'd199, 0, 16'h0006, 16'h0000);
    `CHK("shared", 16'hbeef, rsp.data);
    #1 slvId = 8'd201;
    sTx(8'd201, 1, 16'h044e, 16'h0000);
    `CHK("slvAns", 1'b1, got);
    `CHK("noLedReach", 4'hd, ledOn);
    $display("test slave done");
    conclude();
  end
endmodule // test_mbr_router
